// *** rtl/standby_mode_sequencer.sv ***
// Standby mode sequencer with Wishbone register access
`timescale 1ns/1ns
module standby_mode_sequencer #(
   parameter int FLASH_CYC_P = sb_pkg::FLASH_CYC,
   parameter int SCLK_CYC_P = sb_pkg::SCLK_CYC,
   parameter int MCLK_CYC_P = sb_pkg::MCLK_CYC,
   parameter int MAIN_OSC_STAB_P = sb_pkg::MAIN_OSC_STAB,
   parameter int MAIN_CR_STAB_P = sb_pkg::MAIN_CR_STAB,
   parameter int SUB_OSC_STAB_P = sb_pkg::SUB_OSC_STAB,
   parameter int SUB_CR_STAB_P = sb_pkg::SUB_CR_STAB
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] clk_mode_i,
   input wire logic periph_irq_i,
   input wire logic ext_irq_i,
   input wire logic ram_exec_i,
   input wire logic wdt_standby_i,
   output logic [2:0] clk_sel_o,
   output sb_pkg::clk_en_s clk_en_o
);
   import sb_pkg::*;

   localparam int BOOT_STAB =
      (MAIN_CR_STAB_P > SUB_CR_STAB_P) ? MAIN_CR_STAB_P : SUB_CR_STAB_P;
   localparam int FLASH_MAIN_CYC =
      FLASH_SCLK_MAIN * SCLK_CYC_P + FLASH_CYC_P + FLASH_MCLK * MCLK_CYC_P;
   localparam int FLASH_SUB_CYC =
      FLASH_SCLK_SUB * SCLK_CYC_P + FLASH_CYC_P + FLASH_MCLK * MCLK_CYC_P;

   state_e state_ff;
   state_e nxt_state;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic dstby_dis_ff;
   logic [2:0] clk_sel_ff;
   clk_en_s clk_en_ff;
   clk_en_s nxt_clk_en;

   logic req;
   logic wr_ctrl;
   logic wr_ctrl2;
   logic wr_clksel;
   logic sub_mode;
   logic main_mode;
   logic wake;
   logic need_flash;
   logic osc_load;
   logic flash_load;
   logic osc_busy;
   logic flash_busy;
   logic [CNT_W-1:0] osc_cnt;
   logic [CNT_W-1:0] flash_cnt;

   // Bus decode; writes take effect on the edge where ack is seen
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_ctrl = req & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);
   assign wr_ctrl2 = req & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL2);
   assign wr_clksel = req & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CLKSEL);

   assign sub_mode = (clk_mode_i == SCM_SUB) | (clk_mode_i == SCM_SUBCR);
   assign main_mode = (clk_mode_i == SCM_MAIN) | (clk_mode_i == SCM_MAINCR) |
                      (clk_mode_i == SCM_PLL);
   assign wake = periph_irq_i | ext_irq_i;
   assign need_flash = ~dstby_dis_ff & ~ram_exec_i;

   // Flash recovery length depends on the clock family in use
   always_comb begin
      if (sub_mode) begin
         flash_cnt = CNT_W'(FLASH_SUB_CYC);
      end else begin
         flash_cnt = CNT_W'(FLASH_MAIN_CYC);
      end
   end

   // Stabilization time of the oscillator that must restart
   always_comb begin
      if (state_ff == ST_BOOT) begin
         osc_cnt = CNT_W'(BOOT_STAB);
      end else if (clk_mode_i == SCM_MAIN) begin
         osc_cnt = CNT_W'(MAIN_OSC_STAB_P);
      end else if (clk_mode_i == SCM_SUB) begin
         osc_cnt = CNT_W'(SUB_OSC_STAB_P);
      end else if (clk_mode_i == SCM_SUBCR) begin
         osc_cnt = CNT_W'(SUB_CR_STAB_P);
      end else begin
         osc_cnt = CNT_W'(MAIN_CR_STAB_P);
      end
   end

   // Timers load on the edge that leaves the boot or standby state
   always_comb begin
      osc_load = 1'b0;
      flash_load = 1'b0;
      unique case (state_ff)
         ST_BOOT: begin
            osc_load = 1'b1;
            flash_load = need_flash;
         end
         ST_STOP: begin
            osc_load = ext_irq_i;
            flash_load = ext_irq_i & need_flash;
         end
         ST_SLEEP, ST_TBT, ST_WATCH: begin
            flash_load = wake & need_flash;
         end
         default: begin
            osc_load = 1'b0;
         end
      endcase
   end

   sb_wait_timer u_osc_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(osc_load),
      .count_i(osc_cnt),
      .busy_o(osc_busy)
   );

   sb_wait_timer u_flash_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(flash_load),
      .count_i(flash_cnt),
      .busy_o(flash_busy)
   );

   // Standby requests only count while the CPU runs; stop wins, then watch
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_BOOT: begin
            nxt_state = ST_OSC_WAIT;
         end
         ST_RUN: begin
            if (wr_ctrl && wb_dat_i[BIT_STOP]) begin
               nxt_state = ST_STOP;
            end else if (wr_ctrl && wb_dat_i[BIT_WATCH] && sub_mode) begin
               nxt_state = ST_WATCH;
            end else if (wr_ctrl && wb_dat_i[BIT_WATCH] && main_mode) begin
               nxt_state = ST_TBT;
            end else if (wr_ctrl && wb_dat_i[BIT_SLEEP]) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP, ST_TBT, ST_WATCH: begin
            if (wake) begin
               nxt_state = need_flash ? ST_FLASH : ST_RUN;
            end
         end
         ST_STOP: begin
            if (ext_irq_i) begin
               nxt_state = ST_OSC_WAIT;
            end
         end
         ST_OSC_WAIT: begin
            if (!osc_busy) begin
               nxt_state = flash_busy ? ST_FLASH : ST_RUN;
            end
         end
         ST_FLASH: begin
            if (!flash_busy) begin
               nxt_state = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_BOOT;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_BOOT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Enables are registered from the next state so they change with it
   sb_clock_decode u_decode (
      .state_i(nxt_state),
      .wdt_standby_i(wdt_standby_i),
      .en_o(nxt_clk_en)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_en_ff <= '0;
      end else begin
         clk_en_ff <= nxt_clk_en;
      end
   end

   // Clock select returns to main CR on every reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_sel_ff <= CLK_SEL_RST;
      end else if (wr_clksel) begin
         clk_sel_ff <= wb_dat_i[2:0];
      end
   end

   // Deep standby is the default after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dstby_dis_ff <= DSTBY_RST;
      end else if (wr_ctrl2) begin
         dstby_dis_ff <= wb_dat_i[BIT_DSTBY];
      end
   end

   // Request bits are self-clearing and read back as zero
   always_comb begin
      nxt_rdata = '0;
      unique case (wb_adr_i)
         ADR_CTRL2: begin
            nxt_rdata[BIT_DSTBY] = dstby_dis_ff;
         end
         ADR_CLKSEL: begin
            nxt_rdata[2:0] = clk_sel_ff;
         end
         ADR_STATUS: begin
            nxt_rdata[2:0] = state_ff;
            nxt_rdata[BIT_FLASH_BUSY] = flash_busy;
            nxt_rdata[BIT_OSC_BUSY] = osc_busy;
         end
         default: begin
            nxt_rdata = '0;
         end
      endcase
   end

   // One wait state; unmapped addresses are acked with zero data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= '0;
      end else if (req && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign clk_sel_o = clk_sel_ff;
   assign clk_en_o = clk_en_ff;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_run_write(int b);
      state_ff == ST_RUN && wr_ctrl && wb_dat_i[b];
   endsequence

   sequence s_light_wake;
      (state_ff == ST_SLEEP || state_ff == ST_TBT || state_ff == ST_WATCH) && wake;
   endsequence

   sequence s_stab_done;
      state_ff == ST_OSC_WAIT && !osc_busy;
   endsequence

   a_reset_clksel: assert property (
      $past(rst_i) |-> clk_sel_o == SCM_MAINCR && state_ff == ST_BOOT)
      else $error("clock select not main CR after reset");

   a_boot_stab_wait: assert property (
      state_ff == ST_BOOT |=> state_ff == ST_OSC_WAIT && osc_busy)
      else $error("reset did not wait for oscillator stabilization");

   a_sleep_entry: assert property (
      s_run_write(BIT_SLEEP) ##0
      !wb_dat_i[BIT_STOP] && !wb_dat_i[BIT_WATCH]
      |=> state_ff == ST_SLEEP && !clk_en_o.cpu)
      else $error("sleep request not honoured");

   a_stop_entry: assert property (
      s_run_write(BIT_STOP) |=> state_ff == ST_STOP && !clk_en_o.periph)
      else $error("stop request not honoured");

   a_tbt_entry: assert property (
      s_run_write(BIT_WATCH) ##0 !wb_dat_i[BIT_STOP] && main_mode
      |=> state_ff == ST_TBT)
      else $error("time-base timer mode not entered");

   a_watch_entry: assert property (
      s_run_write(BIT_WATCH) ##0 !wb_dat_i[BIT_STOP] && sub_mode
      |=> state_ff == ST_WATCH)
      else $error("watch mode not entered");

   a_deep_wake: assert property (
      s_light_wake ##0 need_flash
      |=> state_ff == ST_FLASH && !clk_en_o.cpu && clk_en_o.periph ##1 flash_busy)
      else $error("deep wake skipped flash recovery");

   a_stop_exit: assert property (
      state_ff == ST_STOP && ext_irq_i |=> state_ff == ST_OSC_WAIT && osc_busy)
      else $error("stop not left on external interrupt");

   a_stab_short: assert property (
      s_stab_done ##0 flash_busy |=> state_ff == ST_FLASH && clk_en_o.periph)
      else $error("short stabilization did not sleep");

   a_stab_long: assert property (
      s_stab_done ##0 !flash_busy |=> state_ff == ST_RUN && clk_en_o.cpu)
      else $error("long stabilization did not return to run");

   a_ram_skip: assert property (
      s_light_wake ##0 ram_exec_i |=> state_ff == ST_RUN)
      else $error("flash wait taken while running from RAM");

   a_sleep_gates: assert property (
      state_ff == ST_SLEEP |-> !clk_en_o.cpu && !clk_en_o.wdt && clk_en_o.periph)
      else $error("sleep clock gating wrong");

   a_wdt_subcr: assert property (
      $past(wdt_standby_i) && state_ff == ST_SLEEP |-> clk_en_o.sub_cr && clk_en_o.hw_wdt)
      else $error("standby watchdog lost its clock");

   a_normal_wake: assert property (
      s_light_wake ##0 dstby_dis_ff |=> state_ff == ST_RUN ##1 state_ff == ST_RUN)
      else $error("normal standby waited for flash");

   a_flash_hold: assert property (
      state_ff == ST_FLASH && flash_busy |=> state_ff == ST_FLASH && !clk_en_o.cpu)
      else $error("left sleep before flash recovery");
endmodule : standby_mode_sequencer

// *** rtl/sb_pkg.sv ***
// Constants and types of the standby mode sequencer
package sb_pkg;
   localparam int CNT_W = 20;
   localparam int CLK_NS = 4;
   localparam int FLASH_US = 150;
   localparam int FLASH_CYC = FLASH_US * 1000 / CLK_NS;
   localparam int FLASH_SCLK_MAIN = 10;
   localparam int FLASH_SCLK_SUB = 2;
   localparam int FLASH_MCLK = 6;
   localparam int SCLK_CYC = 1;
   localparam int MCLK_CYC = 1;
   localparam int MAIN_OSC_STAB = 2048;
   localparam int MAIN_CR_STAB = 256;
   localparam int SUB_OSC_STAB = 4096;
   localparam int SUB_CR_STAB = 512;
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_CTRL2 = 4'h4;
   localparam logic [3:0] ADR_CLKSEL = 4'h8;
   localparam logic [3:0] ADR_STATUS = 4'hc;
   localparam int BIT_SLEEP = 0;
   localparam int BIT_STOP = 1;
   localparam int BIT_WATCH = 2;
   localparam int BIT_DSTBY = 0;
   localparam int BIT_FLASH_BUSY = 4;
   localparam int BIT_OSC_BUSY = 5;
   localparam logic [2:0] SCM_SUB = 3'h0;
   localparam logic [2:0] SCM_SUBCR = 3'h4;
   localparam logic [2:0] SCM_MAINCR = 3'h2;
   localparam logic [2:0] SCM_MAIN = 3'h6;
   localparam logic [2:0] SCM_PLL = 3'h7;
   localparam logic [2:0] CLK_SEL_RST = SCM_MAINCR;
   localparam logic DSTBY_RST = 1'b0;
   typedef enum logic [2:0] {
      ST_BOOT, ST_RUN, ST_SLEEP, ST_STOP, ST_TBT, ST_WATCH, ST_OSC_WAIT, ST_FLASH
   } state_e;
   typedef struct packed {
      logic cpu;
      logic wdt;
      logic periph;
      logic main_osc;
      logic sub_osc;
      logic sub_cr;
      logic hw_wdt;
   } clk_en_s;
endpackage : sb_pkg

// *** rtl/sb_wait_timer.sv ***
// Loadable down-counter timing one wait
`timescale 1ns/1ns
module sb_wait_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [sb_pkg::CNT_W-1:0] count_i,
   output logic busy_o
);
   import sb_pkg::*;

   logic [CNT_W-1:0] cnt_ff;

   // Busy for exactly count_i cycles after the load edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else if (load_i) begin
         cnt_ff <= count_i;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign busy_o = (cnt_ff != '0);
endmodule : sb_wait_timer

// *** rtl/sb_clock_decode.sv ***
// Clock enables belonging to each sequencer state
`timescale 1ns/1ns
module sb_clock_decode (
   input wire sb_pkg::state_e state_i,
   input wire logic wdt_standby_i,
   output sb_pkg::clk_en_s en_o
);
   import sb_pkg::*;

   always_comb begin
      en_o = '0;
      en_o.sub_cr = wdt_standby_i;
      en_o.hw_wdt = wdt_standby_i;
      unique case (state_i)
         ST_RUN: begin
            en_o = '1;
         end
         ST_SLEEP, ST_FLASH: begin
            en_o.periph = 1'b1;
            en_o.main_osc = 1'b1;
            en_o.sub_osc = 1'b1;
         end
         ST_TBT: begin
            en_o.main_osc = 1'b1;
            en_o.sub_osc = 1'b1;
         end
         ST_WATCH: begin
            en_o.sub_osc = 1'b1;
         end
         ST_STOP: begin
            en_o.main_osc = 1'b0;
         end
         ST_BOOT, ST_OSC_WAIT: begin
            en_o.main_osc = 1'b1;
            en_o.sub_osc = 1'b1;
            en_o.sub_cr = 1'b1;
         end
      endcase
   end
endmodule : sb_clock_decode

// *** sim/sb_irq_source.sv ***
// Interrupt sources on the far side of the standby sequencer
`timescale 1ns/1ns
module sb_irq_source (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_periph_i,
   input wire logic fire_ext_i,
   input wire sb_pkg::clk_en_s clk_en_i,
   output logic periph_irq_o,
   output logic ext_irq_o
);
   import sb_pkg::*;
   // A request stays raised until the CPU runs again and services it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_irq_o <= 1'b0;
         ext_irq_o <= 1'b0;
      end else if (fire_periph_i || fire_ext_i) begin
         periph_irq_o <= periph_irq_o | fire_periph_i;
         ext_irq_o <= ext_irq_o | fire_ext_i;
      end else if (clk_en_i.cpu) begin
         periph_irq_o <= 1'b0;
         ext_irq_o <= 1'b0;
      end
   end
endmodule : sb_irq_source

// *** sim/standby_mode_sequencer_test.sv ***
// Testbench for the standby mode sequencer
`timescale 1ns/1ns
module standby_mode_sequencer_test;
   import sb_pkg::*;
   localparam int FL = 20;
   localparam int NM = 10 + FL + 6;
   localparam int NS = 2 + FL + 6;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack;
   logic [2:0] clk_mode_i = 3'h2;
   logic ram_exec_i = 1'b0;
   logic wdt_standby_i = 1'b0;
   logic fire_per = 1'b0;
   logic fire_ext = 1'b0;
   logic periph_irq;
   logic ext_irq;
   logic [2:0] clk_sel_o;
   clk_en_s clk_en_o;
   int failures = 0;
   int check_count = 0;
   int n;

   sb_irq_source sb_irq_source_inst (.clk_i(clk_i), .rst_i(rst_i), .fire_periph_i(fire_per),
      .fire_ext_i(fire_ext), .clk_en_i(clk_en_o), .periph_irq_o(periph_irq),
      .ext_irq_o(ext_irq));

   // Short waits keep the run brief; long stabilization exceeds flash wait on purpose
   standby_mode_sequencer #(.FLASH_CYC_P(FL),
      .MAIN_OSC_STAB_P(48), .MAIN_CR_STAB_P(8), .SUB_OSC_STAB_P(16), .SUB_CR_STAB_P(4))
   standby_mode_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .clk_mode_i(clk_mode_i), .periph_irq_i(periph_irq),
      .ext_irq_i(ext_irq), .ram_exec_i(ram_exec_i), .wdt_standby_i(wdt_standby_i),
      .clk_sel_o(clk_sel_o), .clk_en_o(clk_en_o));

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task summarize;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   task check_range(input string what, input int lo, input int hi, input int got);
      check_count++;
      if (got < lo || got > hi) begin
         failures++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : check_range

   task wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] d,
                 output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      // Ack comes one cycle after the taking edge, seen at the second edge
      check_val("wb ack cycles", 32'h0000_0002, k);
   endtask : wb_cycle

   task wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask : wr

   task rd(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h0000_0000, q);
      check_val(what, exp, q);
   endtask : rd

   task state_is(input logic [2:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, ADR_STATUS, 32'h0000_0000, q);
      check_val("state", {29'h0, exp}, {29'h0, q[2:0]});
   endtask : state_is

   // Counts cycles from the interrupt request until the CPU clock returns
   task wake(input logic ext, input int lo, input int hi);
      @(posedge clk_i);
      fire_ext <= ext;
      fire_per <= ~ext;
      @(posedge clk_i);
      fire_ext <= 1'b0;
      fire_per <= 1'b0;
      n = 1;
      while (clk_en_o.cpu !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check_range("wake cycles", lo, hi, n);
      state_is(3'h1);
   endtask : wake

   // Stabilization and flash recovery run side by side, so flash recovery sets the pace
   task boot_wait;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      while (clk_en_o.cpu !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check_range("boot cycles", NM, NM + 6, n);
      check_val("clk_sel_o", 32'h0000_0002, {29'h0, clk_sel_o});
   endtask : boot_wait

   initial begin
      boot_wait();
      rd("clksel", ADR_CLKSEL, 32'h0000_0002);
      sel <= 4'he;
      wr(ADR_CTRL2, 32'h0000_0001);
      sel <= 4'hf;
      rd("ctrl2", ADR_CTRL2, 32'h0000_0000);
      rd("unmapped", 4'h2, 32'h0000_0000);
      wr(ADR_CTRL, 32'h0000_0001);
      state_is(3'h2);
      check_val("clk_en", 32'h0000_001c, {25'h0, clk_en_o});
      wdt_standby_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check_val("clk_en", 32'h0000_001f, {25'h0, clk_en_o});
      wdt_standby_i <= 1'b0;
      wake(1'b0, NM, NM + 6);
      // Stop wins over watch and sleep; peripheral request must not end stop
      wr(ADR_CTRL, 32'h0000_0007);
      state_is(3'h3);
      @(posedge clk_i);
      fire_per <= 1'b1;
      @(posedge clk_i);
      fire_per <= 1'b0;
      repeat (4) @(posedge clk_i);
      state_is(3'h3);
      wake(1'b1, NM, NM + 6);
      clk_mode_i <= 3'h6;
      wr(ADR_CTRL, 32'h0000_0002);
      wake(1'b1, 48, 54);
      clk_mode_i <= 3'h7;
      wr(ADR_CTRL, 32'h0000_0004);
      state_is(3'h4);
      wake(1'b0, NM, NM + 6);
      clk_mode_i <= 3'h0;
      wr(ADR_CTRL, 32'h0000_0004);
      state_is(3'h5);
      wake(1'b0, NS, NS + 6);
      clk_mode_i <= 3'h4;
      wr(ADR_CTRL, 32'h0000_0002);
      wake(1'b1, NS, NS + 6);
      clk_mode_i <= 3'h2;
      ram_exec_i <= 1'b1;
      wr(ADR_CTRL, 32'h0000_0001);
      wake(1'b0, 1, 5);
      ram_exec_i <= 1'b0;
      wr(ADR_CTRL2, 32'h0000_0001);
      rd("ctrl2", ADR_CTRL2, 32'h0000_0001);
      wr(ADR_CTRL, 32'h0000_0001);
      wake(1'b0, 1, 5);
      // A reset in sleep must restore main CR select and deep standby
      wr(ADR_CLKSEL, 32'h0000_0006);
      rd("clksel", ADR_CLKSEL, 32'h0000_0006);
      check_val("clk_sel_o", 32'h0000_0006, {29'h0, clk_sel_o});
      wr(ADR_CTRL, 32'h0000_0001);
      state_is(3'h2);
      rst_i <= 1'b1;
      boot_wait();
      rd("ctrl2", ADR_CTRL2, 32'h0000_0000);
      summarize();
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      failures++;
      summarize();
   end
endmodule : standby_mode_sequencer_test
